/* hdl/ubm_map.svh */
/*
 * Register addresses, field positions, reset values and codes of the
 * serial channel and of its controller.
 * Assumes inclusion by bare name from the design and checker files.
 */
`ifndef UBM_MAP_SVH
`define UBM_MAP_SVH

// Device register addresses on the channel's own register port
`define UBM_ADDR_ASYNC_MODE 16'hff70
`define UBM_ADDR_ASYNC_STAT 16'hff71
`define UBM_ADDR_CHAN_MODE 16'hff72
`define UBM_ADDR_BAUD_CTRL 16'hff73
`define UBM_ADDR_DATA 16'hff74
`define UBM_RST_BYTE 8'h00

// Async mode register fields
`define UBM_AM_TXE 7
`define UBM_AM_RXE 6
`define UBM_AM_PAR_HI 5
`define UBM_AM_PAR_LO 4
`define UBM_AM_CL8 3
`define UBM_AM_SL2 2
`define UBM_AM_INT_SRC 0

// Channel mode register fields
`define UBM_CM_WIRE3 7
`define UBM_CM_KEEP 8'h86

// Async status register fields
`define UBM_ST_OVR 0
`define UBM_ST_FE 1
`define UBM_ST_PE 2

// Baud divider control fields and codes
`define UBM_BC_PS_HI 7
`define UBM_BC_PS_LO 4
`define UBM_BC_MOD_HI 3
`define UBM_BC_MOD_LO 0
`define UBM_PS_SLOW 4'h0
`define UBM_PS_FIRST 4'h5
`define UBM_PS_LAST 4'he
`define UBM_PS_SLOW_SHIFT 4'd10
`define UBM_MOD_BASE_M1 5'd15
`define UBM_MOD_WIRE3 4'hf

// Controller APB register offsets
`define UBM_APB_ADDR 8'h00
`define UBM_APB_WRITE 8'h04
`define UBM_APB_READ 8'h08
`define UBM_APB_STAT 8'h0c

`endif

/* hdl/ubm_pkg.sv */
/*
 * Types shared by the serial channel and its controller.
 * Assumes nothing of its surroundings.
 */
package ubm_pkg;
	typedef enum logic [1:0] {
		UBM_STOP = 2'b00,
		UBM_UART = 2'b01,
		UBM_WIRE3 = 2'b10
	} ubm_mode_t;
	typedef enum logic [1:0] {
		UBM_PAR_NONE = 2'b00,
		UBM_PAR_ZERO = 2'b01,
		UBM_PAR_ODD = 2'b10,
		UBM_PAR_EVEN = 2'b11
	} ubm_par_t;
	typedef enum logic [1:0] {
		UBM_H_IDLE = 2'b00,
		UBM_H_WAIT = 2'b01
	} ubm_hst_t;
endpackage : ubm_pkg

/* hdl/ubm_if.sv */
/*
 * Register port between the serial channel and its controller.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface ubm_if;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic chan_busy;
	logic overrun;
	modport dev(
		input reg_addr, reg_wdata, reg_wr, reg_rd,
		output reg_rdata, reg_rvalid, chan_busy, overrun
	);
	modport ctl(
		output reg_addr, reg_wdata, reg_wr, reg_rd,
		input reg_rdata, reg_rvalid, chan_busy, overrun
	);
endinterface : ubm_if
`default_nettype wire

/* hdl/ubm_uart_dev.sv */
/*
 * Serial channel: mode selection, register set, baud generator,
 * UART transmitter and receiver.
 * Assumes a controller on the same clock drives the register port and
 * keeps its own obligations; rxd and the external baud clock are async.
 */
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "ubm_map.svh"
// Notes on behaviour
// (RULE1) Three modes: stopped, UART, three-wire
// (RULE2) Stopped mode: no transfers, pins released
// (RULE3) UART: byte after start bit, full duplex
// (RULE4) Bit clock from system clock or pin
// (RULE5) Pin source: rate is fpin/(2(k+16))
// (RULE6) Modulus field divides by value plus sixteen
// (RULE7) Prescale codes pick system clock divisor
// (RULE8) Oscillator bit selects full or half clock
// (RULE9) Baud control byte at ff73, two fields
// (RULE10) Software never rewrites baud control mid-transfer
// (RULE11) Reset clears all four registers
// (RULE12) Software writes zero for UART mode
// (RULE13) Software keeps reserved mode bits zero
// (RULE14) Internal source frees the baud pin
// (RULE15) Software halts transfers before mode change; controller blocks only ff72 writes, not ff70
// (RULE16) Overrun repeats until buffer is read
// (RULE17) Receiver checks only first stop bit
// (RULE18) Exact 31.25 kbps from system clock
// (RULE19) System source: fxx/(2^n (k+16))
// (RULE20) Frame: start, 7/8 bits, parity, stops
// (RULE21) Only even and odd parity check
// (RULE22) Data write starts frame, done pulse
// (RULE23) Pin clock synchronised before counting
module ubm_uart_dev
	import ubm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce,
	input wire logic oscillator_mode_bit,
	input wire logic ext_baud_clock_in,
	input wire logic rxd_in,
	ubm_if.dev bus,
	output logic txd_out,
	output logic txd_oe_n,
	output logic rx_pin_claim,
	output logic clk_pin_claim,
	output logic transmit_done_irq
);
	logic [7:0] chan_mode_reg_q;
	logic [7:0] async_mode_reg_q;
	logic [7:0] async_status_reg_q;
	logic [7:0] baud_divider_control_q;
	logic [7:0] receive_buffer_q;
	logic rx_full_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic ext_s1_q, ext_s2_q, ext_s3_q;
	logic rxd_s1_q, rxd_s2_q;
	logic fxx_ph_q;
	logic [9:0] pre_q;
	logic [4:0] div_q;
	logic [4:0] rx_div_q;
	logic [11:0] tx_sh_q;
	logic [3:0] tx_cnt_q;
	logic tx_h_q, tx_act_q, txd_q, irq_q;
	logic [9:0] rx_sh_q;
	logic [3:0] rx_idx_q;
	logic rx_h_q, rx_act_q;
	ubm_mode_t mode;
	ubm_par_t par;
	logic wr, rd, bc_wr, tx_go, uart_tx, uart_rx, cl8, sl2;
	logic [3:0] ps, mdl, shift;
	logic pre_ok, mod_ok, fxx_en, ext_rise, src_tick, half_tick, rx_wrap;
	logic [9:0] mask;
	logic [4:0] kmax;
	logic [7:0] tx_d, rx_d;
	logic tx_p, rx_p, rx_done, rx_last, rx_pe;
	logic [3:0] len, nb;
	logic [11:0] frame;
	logic [9:0] rx_w;
	logic rd_rxb;

	assign wr = ce & bus.reg_wr;
	assign rd = ce & bus.reg_rd;
	assign ps = baud_divider_control_q[`UBM_BC_PS_HI:`UBM_BC_PS_LO];
	assign mdl = baud_divider_control_q[`UBM_BC_MOD_HI:`UBM_BC_MOD_LO];
	assign par = ubm_par_t'(async_mode_reg_q[`UBM_AM_PAR_HI:`UBM_AM_PAR_LO]);
	assign cl8 = async_mode_reg_q[`UBM_AM_CL8];
	assign sl2 = async_mode_reg_q[`UBM_AM_SL2];

	// (RULE1) mode decode
	always_comb begin
		if (chan_mode_reg_q[`UBM_CM_WIRE3])
			mode = UBM_WIRE3;
		else if (async_mode_reg_q[`UBM_AM_TXE] | async_mode_reg_q[`UBM_AM_RXE])
			mode = UBM_UART;
		else
			mode = UBM_STOP;
	end
	// (RULE3) full duplex enables
	assign uart_tx = (mode == UBM_UART) & async_mode_reg_q[`UBM_AM_TXE];
	assign uart_rx = (mode == UBM_UART) & async_mode_reg_q[`UBM_AM_RXE];
	// (RULE2) stopped mode frees pins
	assign rx_pin_claim = (mode != UBM_STOP);
	assign txd_oe_n = ~(uart_tx | (mode == UBM_WIRE3));
	// (RULE14) internal source frees pin
	assign clk_pin_claim = (mode == UBM_WIRE3) |
		((mode == UBM_UART) & ~async_mode_reg_q[`UBM_AM_INT_SRC]);
	assign txd_out = txd_q;
	assign transmit_done_irq = irq_q;

	// (RULE11) reset clears registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			chan_mode_reg_q <= `UBM_RST_BYTE;
			async_mode_reg_q <= `UBM_RST_BYTE;
			baud_divider_control_q <= `UBM_RST_BYTE;
		end else if (wr) begin
			if (bus.reg_addr == `UBM_ADDR_CHAN_MODE)
				chan_mode_reg_q <= bus.reg_wdata;
			if (bus.reg_addr == `UBM_ADDR_ASYNC_MODE)
				async_mode_reg_q <= bus.reg_wdata;
			// (RULE9) whole-byte baud write
			if (bc_wr)
				baud_divider_control_q <= bus.reg_wdata;
		end
	end
	assign bc_wr = wr & (bus.reg_addr == `UBM_ADDR_BAUD_CTRL);

	// Register read port, answer one cycle after the strobe
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else if (ce) begin
			rvalid_q <= bus.reg_rd;
			if (rd) begin
				unique case (bus.reg_addr)
					`UBM_ADDR_ASYNC_MODE: rdata_q <= async_mode_reg_q;
					`UBM_ADDR_ASYNC_STAT: rdata_q <= async_status_reg_q;
					`UBM_ADDR_CHAN_MODE: rdata_q <= chan_mode_reg_q;
					`UBM_ADDR_BAUD_CTRL: rdata_q <= baud_divider_control_q;
					`UBM_ADDR_DATA: rdata_q <= receive_buffer_q;
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end
	assign bus.reg_rdata = rdata_q;
	assign bus.reg_rvalid = rvalid_q;
	assign bus.chan_busy = tx_act_q | rx_act_q;
	assign bus.overrun = async_status_reg_q[`UBM_ST_OVR];

	// (RULE23) two-stage pin synchronisers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
		end else if (ce) begin
			ext_s1_q <= ext_baud_clock_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			rxd_s1_q <= rxd_in;
			rxd_s2_q <= rxd_s1_q;
		end
	end
	assign ext_rise = ce & ext_s2_q & ~ext_s3_q;

	// (RULE7) prescale code decode
	always_comb begin
		pre_ok = 1'b1;
		shift = 4'd0;
		if (ps == `UBM_PS_SLOW)
			shift = `UBM_PS_SLOW_SHIFT;
		else if (ps >= `UBM_PS_FIRST && ps <= `UBM_PS_LAST)
			shift = ps - `UBM_PS_FIRST;
		else
			pre_ok = 1'b0;
	end
	assign mask = 10'((11'h001 << shift) - 11'h001);
	// (RULE8) half rate when oscillator bit low
	assign fxx_en = ce & (oscillator_mode_bit | fxx_ph_q);
	// (RULE4) source select
	assign src_tick = async_mode_reg_q[`UBM_AM_INT_SRC] ?
		(fxx_en & pre_ok & ((pre_q & mask) == mask)) : ext_rise;
	// (RULE6) divide by k plus sixteen
	assign kmax = {1'b0, mdl} + `UBM_MOD_BASE_M1;
	assign mod_ok = (mdl != `UBM_MOD_WIRE3);
	// (RULE19) half-bit tick, two per bit
	assign half_tick = src_tick & mod_ok & (div_q == kmax);
	// (RULE5) pin edges counted the same way
	assign rx_wrap = src_tick & mod_ok & (rx_div_q == kmax);

	// (RULE18) exact integer divide chain
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fxx_ph_q <= 1'b0;
			pre_q <= 10'h000;
			div_q <= 5'h00;
		end else if (bc_wr) begin
			fxx_ph_q <= 1'b0;
			pre_q <= 10'h000;
			div_q <= 5'h00;
		end else if (ce) begin
			fxx_ph_q <= ~fxx_ph_q;
			if (fxx_en)
				pre_q <= pre_q + 10'h001;
			if (half_tick)
				div_q <= 5'h00;
			else if (src_tick)
				div_q <= div_q + 5'h01;
		end
	end

	// (RULE20) frame layout
	assign tx_d = cl8 ? bus.reg_wdata : {1'b0, bus.reg_wdata[6:0]};
	always_comb begin
		unique case (par)
			UBM_PAR_EVEN: tx_p = ^tx_d;
			UBM_PAR_ODD: tx_p = ~^tx_d;
			UBM_PAR_ZERO: tx_p = 1'b0;
			UBM_PAR_NONE: tx_p = 1'b1;
		endcase
	end
	assign frame = cl8 ? {2'b11, tx_p, tx_d, 1'b0} :
		{3'b111, tx_p, tx_d[6:0], 1'b0};
	assign len = 4'd1 + (cl8 ? 4'd8 : 4'd7) +
		((par != UBM_PAR_NONE) ? 4'd1 : 4'd0) + (sl2 ? 4'd2 : 4'd1);
	// (RULE17) receiver expects one stop bit
	assign nb = len - 4'd1 - (sl2 ? 4'd1 : 4'd0);

	// (RULE22) data write starts a frame
	assign tx_go = wr & (bus.reg_addr == `UBM_ADDR_DATA) & uart_tx & ~tx_act_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tx_act_q <= 1'b0;
			tx_h_q <= 1'b0;
			tx_cnt_q <= 4'h0;
			tx_sh_q <= 12'hfff;
			txd_q <= 1'b1;
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= 1'b0;
			if (tx_go) begin
				tx_act_q <= 1'b1;
				tx_h_q <= 1'b0;
				tx_sh_q <= frame;
				tx_cnt_q <= len;
				txd_q <= 1'b0;
			end else if (tx_act_q && !uart_tx) begin
				tx_act_q <= 1'b0;
				txd_q <= 1'b1;
			end else if (tx_act_q && half_tick) begin
				tx_h_q <= ~tx_h_q;
				if (tx_h_q) begin
					tx_sh_q <= {1'b1, tx_sh_q[11:1]};
					tx_cnt_q <= tx_cnt_q - 4'd1;
					txd_q <= tx_sh_q[1];
					// (RULE22) done pulse when emptied
					if (tx_cnt_q == 4'd1) begin
						tx_act_q <= 1'b0;
						irq_q <= 1'b1;
						txd_q <= 1'b1;
					end
				end
			end
		end
	end

	// Receiver: own phase counter restarted at the start edge
	assign rx_last = rx_act_q & rx_wrap & ~rx_h_q & (rx_idx_q == nb);
	assign rx_done = ce & rx_last;
	assign rx_w = 10'({rxd_s2_q, rx_sh_q[9:1]} >> (4'd10 - nb));
	assign rx_d = cl8 ? rx_w[7:0] : {1'b0, rx_w[6:0]};
	assign rx_p = cl8 ? rx_w[8] : rx_w[7];
	// (RULE21) only even and odd check
	assign rx_pe = ((par == UBM_PAR_EVEN) & (^rx_d ^ rx_p)) |
		((par == UBM_PAR_ODD) & ~(^rx_d ^ rx_p));
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_act_q <= 1'b0;
			rx_h_q <= 1'b0;
			rx_idx_q <= 4'h0;
			rx_div_q <= 5'h00;
			rx_sh_q <= 10'h000;
		end else if (ce) begin
			if (!uart_rx) begin
				rx_act_q <= 1'b0;
			end else if (!rx_act_q) begin
				if (!rxd_s2_q) begin
					rx_act_q <= 1'b1;
					rx_h_q <= 1'b0;
					rx_idx_q <= 4'h0;
					rx_div_q <= 5'h00;
				end
			end else begin
				if (rx_wrap)
					rx_div_q <= 5'h00;
				else if (src_tick)
					rx_div_q <= rx_div_q + 5'h01;
				if (rx_wrap) begin
					rx_h_q <= ~rx_h_q;
					if (!rx_h_q) begin
						rx_idx_q <= rx_idx_q + 4'd1;
						if (rx_idx_q != 4'h0)
							rx_sh_q <= {rxd_s2_q, rx_sh_q[9:1]};
						if ((rx_idx_q == 4'h0 && rxd_s2_q) || rx_last)
							rx_act_q <= 1'b0;
					end
				end
			end
		end
	end

	// (RULE16) overrun repeats while buffer unread
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			async_status_reg_q <= `UBM_RST_BYTE;
			receive_buffer_q <= 8'h00;
			rx_full_q <= 1'b0;
		end else if (ce) begin
			if (rx_done) begin
				async_status_reg_q <= 8'h00;
				async_status_reg_q[`UBM_ST_PE] <= rx_pe;
				async_status_reg_q[`UBM_ST_FE] <= ~rxd_s2_q;
				async_status_reg_q[`UBM_ST_OVR] <= rx_full_q & ~rd_rxb;
				rx_full_q <= 1'b1;
				if (!rx_full_q || rd_rxb)
					receive_buffer_q <= rx_d;
			end else if (rd_rxb) begin
				rx_full_q <= 1'b0;
			end
		end
	end
	assign rd_rxb = rd & (bus.reg_addr == `UBM_ADDR_DATA);
endmodule : ubm_uart_dev
`default_nettype wire

/* hdl/ubm_ctrl.sv */
/*
 * Controller end: APB slave that turns software orders into register
 * accesses on the channel and keeps the software-side obligations except RULE12 and, for ff70 writes, RULE15.
 * Assumes the channel shares clk_sys and answers reads a cycle later.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ubm_map.svh"
module ubm_ctrl
	import ubm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	ubm_if.ctl bus
);
	ubm_hst_t state_q;
	logic [15:0] addr_q;
	logic [15:0] dev_addr_q;
	logic [7:0] dev_wdata_q;
	logic dev_wr_q, dev_rd_q;
	logic [7:0] rd_data_q, drain_data_q;
	logic refused_q, drained_q, drain_q, ovr_prev_q, ovr_pend_q;
	logic [31:0] prdata_q;
	logic acc, wr_go, rd_go, mapped, guard, is_chan;
	logic [7:0] off;

	assign off = paddr[7:0];
	assign mapped = (paddr[31:8] == 24'h000000) &&
		(off == `UBM_APB_ADDR || off == `UBM_APB_WRITE ||
		off == `UBM_APB_READ || off == `UBM_APB_STAT);
	assign acc = ce & psel & penable & pwrite & mapped;
	assign wr_go = acc & (off == `UBM_APB_WRITE);
	assign rd_go = acc & (off == `UBM_APB_READ);
	assign is_chan = (addr_q == `UBM_ADDR_CHAN_MODE);
	// (RULE10) no baud write during transfer
	// (RULE15) no channel mode register write during transfer
	assign guard = (state_q != UBM_H_IDLE) | dev_wr_q | dev_rd_q |
		(wr_go & bus.chan_busy & (is_chan | (addr_q == `UBM_ADDR_BAUD_CTRL)));
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prdata_q <= 32'h00000000;
		end else if (ce && psel && !penable && !pwrite) begin
			unique case (off)
				`UBM_APB_ADDR: prdata_q <= {16'h0000, addr_q};
				`UBM_APB_STAT: prdata_q <= {8'h00, drain_data_q, rd_data_q,
					4'h0, bus.chan_busy, drained_q, refused_q,
					state_q != UBM_H_IDLE};
				default: prdata_q <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			addr_q <= 16'h0000;
		else if (acc && off == `UBM_APB_ADDR)
			addr_q <= pwdata[15:0];
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= UBM_H_IDLE;
			dev_addr_q <= 16'h0000;
			dev_wdata_q <= 8'h00;
			dev_wr_q <= 1'b0;
			dev_rd_q <= 1'b0;
			refused_q <= 1'b0;
			drain_q <= 1'b0;
			drained_q <= 1'b0;
			ovr_prev_q <= 1'b0;
			ovr_pend_q <= 1'b0;
			rd_data_q <= 8'h00;
			drain_data_q <= 8'h00;
		end else if (ce) begin
			dev_wr_q <= 1'b0;
			dev_rd_q <= 1'b0;
			ovr_prev_q <= bus.overrun;
			if (bus.overrun && !ovr_prev_q)
				ovr_pend_q <= 1'b1;
			if ((wr_go || rd_go) && guard) begin
				refused_q <= 1'b1;
			end else if (wr_go || rd_go) begin
				refused_q <= 1'b0;
				dev_addr_q <= addr_q;
				dev_wr_q <= wr_go;
				dev_rd_q <= rd_go;
				// (RULE13) reserved mode bits forced zero
				// (RULE12) UART selection not forced to zero; ff72 bits 7, 2 and 1 pass as written
				dev_wdata_q <= is_chan ? (pwdata[7:0] & `UBM_CM_KEEP) :
					pwdata[7:0];
				if (rd_go)
					state_q <= UBM_H_WAIT;
			end else if (state_q == UBM_H_IDLE && !dev_wr_q && !dev_rd_q &&
				(ovr_pend_q || (bus.overrun && !ovr_prev_q))) begin
				// (RULE16) drain buffer after overrun
				dev_addr_q <= `UBM_ADDR_DATA;
				dev_rd_q <= 1'b1;
				drain_q <= 1'b1;
				ovr_pend_q <= 1'b0;
				state_q <= UBM_H_WAIT;
			end
			if (state_q == UBM_H_WAIT && bus.reg_rvalid) begin
				state_q <= UBM_H_IDLE;
				drain_q <= 1'b0;
				if (drain_q) begin
					drain_data_q <= bus.reg_rdata;
					drained_q <= 1'b1;
				end else begin
					rd_data_q <= bus.reg_rdata;
				end
			end
		end
	end
	assign bus.reg_addr = dev_addr_q;
	assign bus.reg_wdata = dev_wdata_q;
	assign bus.reg_wr = dev_wr_q;
	assign bus.reg_rd = dev_rd_q;
endmodule : ubm_ctrl
`default_nettype wire

/* verification/ubm_port_checker.sv */
/*
 * Assertions on the register port between the channel and its controller.
 * Assumes one clock domain, instantiated beside the joining interface.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ubm_map.svh"
module ubm_port_checker (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic chan_busy,
	input wire logic overrun
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read strobe not answered");
	property p_rvalid_cause; reg_rvalid |-> $past(reg_rd); endproperty
	a_rvalid_cause: assert property (p_rvalid_cause)
		else $error("answer without read strobe");
	property p_one_strobe; !(reg_wr && reg_rd); endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("two strobes in one cycle");
	property p_wr_pulse; reg_wr |=> !reg_wr; endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write strobe longer than a cycle");
	property p_rdata_hold; $changed(reg_rdata) |-> reg_rvalid; endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without answer");
	property p_mode_mask;
		reg_wr && reg_addr == `UBM_ADDR_CHAN_MODE |->
			(reg_wdata & ~`UBM_CM_KEEP) == 8'h00;
	endproperty
	a_mode_mask: assert property (p_mode_mask)
		else $error("reserved mode bits written");
	property p_no_baud_mid;
		reg_wr && (reg_addr == `UBM_ADDR_BAUD_CTRL ||
			reg_addr == `UBM_ADDR_CHAN_MODE)
			|-> !$past(chan_busy);
	endproperty
	a_no_baud_mid: assert property (p_no_baud_mid)
		else $error("setup written during transfer");
	property p_ovr_drain;
		$rose(overrun) |-> ##[0:6] (reg_rd && reg_addr == `UBM_ADDR_DATA);
	endproperty
	a_ovr_drain: assert property (p_ovr_drain)
		else $error("receive buffer not read on overrun");
	property p_reset_clear; $rose(resetn) |-> !overrun && !chan_busy; endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("status not clear after reset");
endmodule : ubm_port_checker
`default_nettype wire

/* verification/uart_baud_and_mode_setup_tb.sv */
/*
 * Testbench: controller and channel joined by the interface, APB master,
 * looped serial line and a model of frames and bit periods.
 * Assumes the design files are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module uart_baud_and_mode_setup_tb
	import ubm_pkg::*;
;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, e;
	logic osc_q = 1'b1;
	logic ext_q = 1'b0;
	logic [2:0] ext_cnt = 3'h0;
	logic txd_out, txd_oe_n, rx_claim, clk_claim, irq;
	logic [31:0] rnd = 32'd34926;
	logic [7:0] b, d0;
	logic [7:0] exp_q [$];
	int err_total = 0;
	int cmp_count = 0;
	int irq_cnt = 0;
	int c, i, n0;
	logic [7:0] cfg_b [6] = '{8'h50, 8'h53, 8'h6e, 8'h5e, 8'h00, 8'hb9};
	logic [7:0] cfg_a [6] = '{8'hc9, 8'hf9, 8'he5, 8'hd9, 8'hc8, 8'hc9};
	logic cfg_o [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
	always #5 clk_sys = ~clk_sys;
	// Pin clock of six system cycles
	always @(posedge clk_sys) begin
		ext_cnt <= (ext_cnt == 3'd2) ? 3'd0 : ext_cnt + 3'd1;
		if (ext_cnt == 3'd2) ext_q <= ~ext_q;
	end
	always @(posedge clk_sys) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
	ubm_if uif();
	ubm_uart_dev ubm_uart_dev_inst (.clk_sys(clk_sys), .resetn(resetn),
		.ce(1'b1), .oscillator_mode_bit(osc_q), .ext_baud_clock_in(ext_q),
		.rxd_in(txd_out), .bus(uif.dev), .txd_out(txd_out),
		.txd_oe_n(txd_oe_n), .rx_pin_claim(rx_claim),
		.clk_pin_claim(clk_claim), .transmit_done_irq(irq));
	ubm_ctrl ubm_ctrl_inst (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(uif.ctl));
	ubm_port_checker ubm_port_checker_inst (.clk_sys(clk_sys),
		.resetn(resetn), .reg_addr(uif.reg_addr), .reg_wdata(uif.reg_wdata),
		.reg_wr(uif.reg_wr), .reg_rd(uif.reg_rd), .reg_rdata(uif.reg_rdata),
		.reg_rvalid(uif.reg_rvalid), .chan_busy(uif.chan_busy),
		.overrun(uif.overrun));
	task end_of_test;
		if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task tmo;
		chk(32'h0, 32'h1);
		end_of_test();
	endtask : tmo
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	// Cycles per bit: pin ticks or 2^n (k+16) system ticks
	function automatic int bitc(input logic [7:0] bc, input logic [7:0] am,
		input logic osc);
		int n;
		if (!am[0]) return 2 * (bc[3:0] + 16) * 6;
		n = (bc[7:4] == 4'h0) ? 11 : bc[7:4] - 4;
		return (1 << n) * (bc[3:0] + 16) * (osc ? 1 : 2);
	endfunction : bitc
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (k == 20) tmo();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task dev_wr(input logic [15:0] a, input logic [7:0] d);
		apb(1'b1, 32'h0, {16'h0, a});
		apb(1'b1, 32'h4, {24'h0, d});
		repeat (2) @(negedge clk_sys);
	endtask : dev_wr
	task dev_rd(input logic [15:0] a, output logic [7:0] d);
		int k;
		apb(1'b1, 32'h0, {16'h0, a});
		apb(1'b1, 32'h8, 32'h0);
		for (k = 0; k < 20; k++) begin
			apb(1'b0, 32'hc, 32'h0);
			if (r[0] === 1'b0) break;
		end
		if (k == 20) tmo();
		d = r[15:8];
	endtask : dev_rd
	task chk_frame(input logic [7:0] d, input logic [7:0] am, input int bc);
		int k, n;
		logic [11:0] fr;
		logic p;
		fr = '1;
		fr[0] = 1'b0;
		n = am[3] ? 8 : 7;
		for (k = 0; k < n; k++) fr[k + 1] = d[k];
		p = ^(d & (am[3] ? 8'hff : 8'h7f));
		if (am[5:4] != 2'b00) fr[n + 1] = (am[5:4] == 2'b11) ? p :
			(am[5:4] == 2'b10) ? ~p : 1'b0;
		n = 2 + n + (am[5:4] != 2'b00) + am[2];
		for (k = 0; k < 8 * bc; k++) begin
			@(negedge clk_sys);
			if (txd_out === 1'b0) break;
		end
		if (k == 8 * bc) tmo();
		repeat (bc / 2) @(negedge clk_sys);
		for (k = 0; k < n; k++) begin
			chk({31'h0, txd_out}, {31'h0, fr[k]});
			repeat (bc) @(negedge clk_sys);
		end
	endtask : chk_frame
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		for (i = 0; i < 4; i++) begin
			dev_rd(16'hff70 + i[15:0], b);
			chk(b, 8'h00);
		end
		apb(1'b1, 32'h10, 32'h0);
		chk(e, 1'b1);
		dev_wr(16'hff72, 8'hff);
		dev_rd(16'hff72, b);
		chk(b, 8'h86);
		dev_wr(16'hff72, 8'h80);
		chk(rx_claim, 1'b1);
		chk(txd_oe_n, 1'b0);
		dev_wr(16'hff72, 8'h00);
		chk({rx_claim, clk_claim, txd_oe_n}, 3'b001);
		for (c = 0; c < 6; c++) begin
			@(posedge clk_sys) osc_q <= cfg_o[c];
			dev_wr(16'hff73, cfg_b[c]);
			dev_wr(16'hff70, cfg_a[c]);
			chk(clk_claim, !cfg_a[c][0]);
			rnd = xs(rnd);
			d0 = rnd[7:0];
			exp_q.push_back(d0 & (cfg_a[c][3] ? 8'hff : 8'h7f));
			n0 = irq_cnt;
			fork
				chk_frame(d0, cfg_a[c], bitc(cfg_b[c], cfg_a[c], cfg_o[c]));
				dev_wr(16'hff74, d0);
			join
			chk(irq_cnt - n0, 1);
			dev_rd(16'hff74, b);
			chk(b, exp_q.pop_front());
			dev_rd(16'hff71, b);
			chk(b, 8'h00);
		end
		dev_wr(16'hff73, 8'h50);
		exp_q.push_back(8'h5a);
		fork chk_frame(8'h5a, 8'hc9, 32); dev_wr(16'hff74, 8'h5a); join
		// Second frame unread; baud write mid-frame
		fork
			chk_frame(8'ha5, 8'hc9, 32);
			begin
				dev_wr(16'hff74, 8'ha5);
				for (i = 0; i < 40; i++) begin
					apb(1'b0, 32'hc, 32'h0);
					if (r[3] === 1'b1) break;
				end
				dev_wr(16'hff73, 8'h00);
				apb(1'b0, 32'hc, 32'h0);
				chk(r[1], 1'b1);
			end
		join
		apb(1'b0, 32'hc, 32'h0);
		d0 = exp_q.pop_front();
		chk({r[2], r[23:16]}, {1'b1, d0});
		dev_rd(16'hff71, b);
		chk(b[0], 1'b1);
		dev_rd(16'hff73, b);
		chk(b, 8'h50);
		// Prohibited prescale code gives no ticks
		dev_wr(16'hff73, 8'h30);
		dev_wr(16'hff74, 8'h00);
		repeat (200) @(negedge clk_sys);
		chk(txd_out, 1'b0);
		dev_wr(16'hff70, 8'h00);
		repeat (2) @(negedge clk_sys);
		chk({txd_out, txd_oe_n}, 2'b11);
		chk(exp_q.size(), 0);
		end_of_test();
	end
endmodule : uart_baud_and_mode_setup_tb
`default_nettype wire
